//--- src/osd_offset_stop.sv
// Purpose: stop-distance parameter and trigger offset stop sequencing
// Assumes: motion inputs on ref_clk, trigger pin asynchronous
// Notes: apb slave with no wait states, errors on pslverr
//
// Overview of operation
// - distance accepted only from zero to limit
// - new distance used at once
// - store written only on save command
// - power-up loads saved value or zero
// - host distance writes only in mode zero
// - trigger during continuous move stops after distance
// - offset velocity first, then decelerate to stop
// - only with action two and assigned input
`timescale 1ns/10ps
module osd_offset_stop
  import osd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // stored sequence writes
  input wire logic seqDistWr,
  input wire logic [31:0] seqDistData,
  input wire logic seqSave,
  // motion profile generator
  input wire logic [31:0] motorPos,
  input wire logic continuousMovePositive,
  input wire logic continuousMoveNegative,
  input wire logic [31:0] brakeDistance,
  output logic offsetVelSelect,
  output logic [31:0] offsetVelocity,
  output logic decelRequest,
  output logic stopRequest,
  output logic [31:0] stopTarget,
  output logic offsetActive,
  // trigger pin
  input wire logic triggerPin,
  // nonvolatile store
  output logic nvReadReq,
  input wire logic nvReadAck,
  input wire logic nvReadValid,
  input wire logic [31:0] nvReadData,
  output logic nvWriteReq,
  output logic [31:0] nvWriteData,
  input wire logic nvWriteAck
);

  // range check, shared by host and sequence paths
  function automatic logic distOk(input logic [31:0] value, input logic [31:0] limit);
    distOk = (value <= limit); // unsigned, so zero is the floor
  endfunction : distOk

  // software-visible state
  logic [OSD_MODE_W-1:0] opMode; // operating mode, zero means immediate
  logic [OSD_ACT_W-1:0] triggerActionSelect; // trigger action selector
  logic triggerAssigned; // trigger function mapped to a pin
  logic [31:0] triggerOffsetDistance; // live stop distance
  logic [31:0] triggerOffsetVelocity; // speed after the trigger
  logic [31:0] maxPositionLimit; // upper bound for the distance
  logic rejected; // sticky: a distance write was refused

  // sequencer state
  osd_state_t state;
  osd_state_t next_state;
  logic dirNegative; // direction latched at trigger

  // submodule links
  osd_trig_if trig ();
  logic loadStrobe;
  logic [31:0] loadValue;

  // apb phase decode
  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready;
  wire hostWr = accessDone & pwrite;

  // address decode
  wire selCtrl = (paddr == OSD_ADDR_CTRL);
  wire selDist = (paddr == OSD_ADDR_DIST);
  wire selVel = (paddr == OSD_ADDR_VEL);
  wire selMax = (paddr == OSD_ADDR_MAX_POSITION_LIMIT);
  wire selCmd = (paddr == OSD_ADDR_CMD);
  wire selStat = (paddr == OSD_ADDR_STAT);
  wire selCap = (paddr == OSD_ADDR_CAPPOS);
  wire addrHit = selCtrl | selDist | selVel | selMax | selCmd | selStat | selCap;

  // distance write acceptance
  wire modeOk = (opMode == OSD_MODE_IMMEDIATE);
  wire hostDistWr = hostWr & selDist;
  wire hostDistGood = modeOk & distOk(pwdata, maxPositionLimit);
  wire seqDistGood = distOk(seqDistData, maxPositionLimit);
  // sequence path takes the cycle when both arrive together
  wire distWrOk = seqDistWr ? seqDistGood : (hostDistWr & hostDistGood);
  wire [31:0] distWrData = seqDistWr ? seqDistData : pwdata;
  wire rejectSet = (seqDistWr & ~seqDistGood) | (~seqDistWr & hostDistWr & ~hostDistGood);
  wire rejectClr = hostWr & selStat & pwdata[OSD_STAT_REJ_BIT];

  // error known already in the setup phase
  wire setupErr = ~addrHit | (pwrite & selDist & ~hostDistGood);
  wire saveParametersCmd = (hostWr & selCmd & pwdata[OSD_CMD_SAVE_BIT]) | seqSave;

  // status word
  wire [31:0] statWord = {24'h00_0000, state, 1'b0, offsetActive, nvWriteReq, rejected};

  // read selection
  wire [31:0] ctrlWord = {23'h00_0000, triggerAssigned, 2'h0, triggerActionSelect, opMode};
  wire [31:0] rdValue = selCtrl ? ctrlWord :
                        selDist ? triggerOffsetDistance :
                        selVel ? triggerOffsetVelocity :
                        selMax ? maxPositionLimit :
                        selStat ? statWord :
                        selCap ? trig.capPos : OSD_ZERO;

  // apb answer: ready in the first access cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= OSD_ZERO;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase & setupErr;
      prdata <= (setupPhase & ~pwrite) ? rdValue : OSD_ZERO;
    end
  end

  // control, velocity and limit registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      opMode <= OSD_MODE_IMMEDIATE;
      triggerActionSelect <= 2'h0;
      triggerAssigned <= 1'b0;
      triggerOffsetVelocity <= OSD_VEL_INIT;
      maxPositionLimit <= OSD_MAX_POSITION_LIMIT_INIT;
    end else begin
      if (hostWr & selCtrl) begin
        opMode <= pwdata[OSD_CTRL_MODE_LSB +: OSD_MODE_W];
        triggerActionSelect <= pwdata[OSD_CTRL_ACT_LSB +: OSD_ACT_W];
        triggerAssigned <= pwdata[OSD_CTRL_ASSIGN_BIT];
      end
      if (hostWr & selVel) begin
        triggerOffsetVelocity <= pwdata;
      end
      if (hostWr & selMax) begin
        maxPositionLimit <= pwdata;
      end
    end
  end

  // stop distance: power-up load first, then checked writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      triggerOffsetDistance <= OSD_DIST_INIT;
    end else if (loadStrobe) begin
      triggerOffsetDistance <= loadValue;
    end else if (distWrOk) begin
      triggerOffsetDistance <= distWrData;
    end
  end

  // refused-write flag, a new refusal beats the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rejected <= 1'b0;
    end else begin
      rejected <= rejectSet | (rejected & ~rejectClr);
    end
  end

  // nonvolatile load and save
  osd_nv_store u_nv (
    .ref_clk(ref_clk),
    .rst(rst),
    .saveCmd(saveParametersCmd),
    .saveData(triggerOffsetDistance),
    .loadStrobe(loadStrobe),
    .loadValue(loadValue),
    .nvReadReq(nvReadReq),
    .nvReadAck(nvReadAck),
    .nvReadValid(nvReadValid),
    .nvReadData(nvReadData),
    .nvWriteReq(nvWriteReq),
    .nvWriteData(nvWriteData),
    .nvWriteAck(nvWriteAck)
  );

  // trigger synchroniser and position capture
  osd_trig_capture u_trig (
    .ref_clk(ref_clk),
    .rst(rst),
    .triggerPin(triggerPin),
    .motorPos(motorPos),
    .trig(trig)
  );

  // arming and start conditions
  wire armed = (triggerActionSelect == OSD_ACT_OFFSET) & triggerAssigned;
  wire moving = continuousMovePositive | continuousMoveNegative;
  wire startOffset = (state == OSD_S_IDLE) & trig.trigEdge & armed & moving;
  wire startNeg = ~continuousMovePositive & continuousMoveNegative;
  // target from the caught position, live distance used
  wire [31:0] startTarget = startNeg ? (trig.capPos - triggerOffsetDistance)
                                     : (trig.capPos + triggerOffsetDistance);

  // distance left, signed; negative means overshoot
  wire [31:0] remaining = dirNegative ? (motorPos - stopTarget) : (stopTarget - motorPos);
  wire reachedEnd = remaining[31] | (remaining == OSD_ZERO);
  wire nearEnd = remaining[31] | (remaining <= brakeDistance);

  // next state; a dropped move command aborts the sequence
  always_comb begin
    next_state = state;
    case (state)
      OSD_S_IDLE: begin
        if (startOffset) begin
          next_state = OSD_S_CRUISE;
        end
      end
      OSD_S_CRUISE: begin
        if (~moving) begin
          next_state = OSD_S_IDLE;
        end else if (nearEnd) begin
          next_state = OSD_S_DECEL;
        end
      end
      OSD_S_DECEL: begin
        if (~moving) begin
          next_state = OSD_S_IDLE;
        end else if (reachedEnd) begin
          next_state = OSD_S_HALT;
        end
      end
      OSD_S_HALT: begin
        if (~moving) begin
          next_state = OSD_S_IDLE;
        end
      end
      default: begin
        next_state = OSD_S_IDLE;
      end
    endcase
  end

  // state, direction and target
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= OSD_S_IDLE;
      dirNegative <= 1'b0;
      stopTarget <= OSD_ZERO;
    end else begin
      state <= next_state;
      if (startOffset) begin
        dirNegative <= startNeg;
        stopTarget <= startTarget;
      end
    end
  end

  // profile commands follow the next state so they line up with it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      offsetVelSelect <= 1'b0;
      decelRequest <= 1'b0;
      stopRequest <= 1'b0;
      offsetActive <= 1'b0;
      offsetVelocity <= OSD_VEL_INIT;
    end else begin
      offsetVelSelect <= (next_state != OSD_S_IDLE);
      decelRequest <= (next_state == OSD_S_DECEL) | (next_state == OSD_S_HALT);
      stopRequest <= (next_state == OSD_S_HALT);
      offsetActive <= (next_state != OSD_S_IDLE);
      offsetVelocity <= triggerOffsetVelocity;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  dist_write_a: assert property (distWrOk && !loadStrobe |=>
    triggerOffsetDistance == $past(distWrData))
    else $error("accepted distance not stored");
  dist_reject_a: assert property (rejectSet && !loadStrobe |=>
    $stable(triggerOffsetDistance) && rejected)
    else $error("refused distance changed the value");
  host_mode_a: assert property (hostDistWr && !modeOk && !seqDistWr |=>
    rejected)
    else $error("host write outside mode zero not refused");
  save_only_a: assert property ($rose(nvWriteReq) |-> $past(saveParametersCmd))
    else $error("store written without save");
  load_value_a: assert property (loadStrobe |=> triggerOffsetDistance == $past(loadValue))
    else $error("power-up value not loaded");
  unarmed_idle_a: assert property (state == OSD_S_IDLE && !armed |=> state == OSD_S_IDLE)
    else $error("offset stop started while unarmed");
  start_seq_a: assert property (startOffset |=> state == OSD_S_CRUISE &&
    offsetVelSelect && stopTarget == $past(startTarget))
    else $error("trigger did not start offset stop");
  decel_order_a: assert property ($rose(decelRequest) |-> $past(offsetVelSelect))
    else $error("deceleration before offset speed");
  halt_reach_a: assert property (state == OSD_S_DECEL && reachedEnd && moving |=>
    stopRequest && decelRequest)
    else $error("no stop at end of distance");
  apb_ready_a: assert property (setupPhase |=> pready ##1 !pready)
    else $error("apb answer not in first access cycle");

  offset_start_c: cover property (startOffset ##[1:1000] stopRequest);
  dist_refused_c: cover property (rejectSet);
  save_done_c: cover property (nvWriteReq ##[1:20] nvWriteAck);
  aborted_c: cover property (state == OSD_S_CRUISE ##1 state == OSD_S_IDLE);

endmodule : osd_offset_stop

//--- src/osd_pkg.sv
// Purpose: shared constants and types of the trigger offset stop block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: all offsets are byte addresses on the register bus
package osd_pkg;

  // bus geometry
  localparam int OSD_ADDR_W = 12;
  localparam int OSD_DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] OSD_ADDR_CTRL = 12'h000;
  localparam logic [11:0] OSD_ADDR_DIST = 12'h004;
  localparam logic [11:0] OSD_ADDR_VEL = 12'h008;
  localparam logic [11:0] OSD_ADDR_MAX_POSITION_LIMIT = 12'h00c;
  localparam logic [11:0] OSD_ADDR_CMD = 12'h010;
  localparam logic [11:0] OSD_ADDR_STAT = 12'h014;
  localparam logic [11:0] OSD_ADDR_CAPPOS = 12'h018;

  // control register fields
  localparam int OSD_CTRL_MODE_LSB = 0;
  localparam int OSD_MODE_W = 4;
  localparam int OSD_CTRL_ACT_LSB = 4;
  localparam int OSD_ACT_W = 2;
  localparam int OSD_CTRL_ASSIGN_BIT = 8;

  // field values
  localparam logic [3:0] OSD_MODE_IMMEDIATE = 4'h0;
  localparam logic [1:0] OSD_ACT_OFFSET = 2'h2;

  // command and status bits
  localparam int OSD_CMD_SAVE_BIT = 0;
  localparam int OSD_STAT_REJ_BIT = 0;
  localparam int OSD_STAT_NVBUSY_BIT = 1;
  localparam int OSD_STAT_ACTIVE_BIT = 2;
  localparam int OSD_STAT_STATE_LSB = 4;

  // reset values
  localparam logic [31:0] OSD_DIST_INIT = 32'h0000_0000;
  localparam logic [31:0] OSD_VEL_INIT = 32'h0000_0001;
  localparam logic [31:0] OSD_MAX_POSITION_LIMIT_INIT = 32'h0000_ffff;
  localparam logic [31:0] OSD_ZERO = 32'h0000_0000;

  // offset stop sequencer states
  typedef enum logic [3:0] {
    OSD_S_IDLE = 4'b0001,
    OSD_S_CRUISE = 4'b0010,
    OSD_S_DECEL = 4'b0100,
    OSD_S_HALT = 4'b1000
  } osd_state_t;

endpackage : osd_pkg

//--- src/osd_trig_if.sv
// Purpose: carries the detected trigger event and the position caught with it
// Assumes: both ends on ref_clk
// Notes: trigEdge is a one-cycle pulse, capPos holds until the next event
`timescale 1ns/10ps
interface osd_trig_if;
  logic trigEdge; // one cycle per detected trigger
  logic [31:0] capPos; // motor position at that trigger

  // detector side
  modport src (output trigEdge, output capPos);
  // sequencer side
  modport dst (input trigEdge, input capPos);
endinterface : osd_trig_if

//--- src/osd_trig_capture.sv
// Purpose: synchronise the trigger pin and catch the position at its edge
// Assumes: trigger active high, asynchronous to ref_clk
// Notes: two-stage synchroniser, first stage read only by the second
`timescale 1ns/10ps
module osd_trig_capture
  import osd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pin and position
  input wire logic triggerPin,
  input wire logic [31:0] motorPos,
  // event out
  osd_trig_if.src trig
);

  logic syncA; // metastability stage
  logic syncB; // settled level
  logic syncPrev; // previous settled level for edge detect
  wire riseSeen = syncB & ~syncPrev;

  // synchroniser and edge history
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncPrev <= 1'b0;
    end else begin
      syncA <= triggerPin;
      syncB <= syncA;
      syncPrev <= syncB;
    end
  end

  // pulse plus position snapshot in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trig.trigEdge <= 1'b0;
      trig.capPos <= OSD_ZERO;
    end else begin
      trig.trigEdge <= riseSeen;
      if (riseSeen) begin
        trig.capPos <= motorPos;
      end
    end
  end

endmodule : osd_trig_capture

//--- src/osd_nv_store.sv
// Purpose: power-up load and explicit save of the stop distance
// Assumes: nonvolatile store answers with one-cycle acks on ref_clk
// Notes: a save requested while one is pending is dropped
`timescale 1ns/10ps
module osd_nv_store
  import osd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // block side
  input wire logic saveCmd,
  input wire logic [31:0] saveData,
  output logic loadStrobe,
  output logic [31:0] loadValue,
  // store side
  output logic nvReadReq,
  input wire logic nvReadAck,
  input wire logic nvReadValid,
  input wire logic [31:0] nvReadData,
  output logic nvWriteReq,
  output logic [31:0] nvWriteData,
  input wire logic nvWriteAck
);

  // load once after reset: saved value, else the initial value
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nvReadReq <= 1'b1;
      loadStrobe <= 1'b0;
      loadValue <= OSD_DIST_INIT;
    end else begin
      loadStrobe <= nvReadReq & nvReadAck;
      if (nvReadReq & nvReadAck) begin
        nvReadReq <= 1'b0;
        loadValue <= nvReadValid ? nvReadData : OSD_DIST_INIT;
      end
    end
  end

  // write only on an explicit save command
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nvWriteReq <= 1'b0;
      nvWriteData <= OSD_ZERO;
    end else if (saveCmd & ~nvWriteReq) begin
      nvWriteReq <= 1'b1;
      nvWriteData <= saveData;
    end else if (nvWriteAck) begin
      nvWriteReq <= 1'b0;
    end
  end

endmodule : osd_nv_store

//--- verif/osd_far_model.sv
// Purpose: far side of the offset stop block: store and motion
// Assumes: one clock, store keeps its word across rst
// Notes: reads answer at once, writes after a few cycles
`timescale 1ns/10ps
module osd_far_model
  import osd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // motion side
  input wire logic continuousMovePositive,
  input wire logic continuousMoveNegative,
  input wire logic stopRequest,
  output logic [31:0] motorPos,
  // store side
  input wire logic nvReadReq,
  output logic nvReadAck,
  output logic nvReadValid,
  output logic [31:0] nvReadData,
  input wire logic nvWriteReq,
  input wire logic [31:0] nvWriteData,
  output logic nvWriteAck
);
  logic [31:0] savedWord; // survives rst, like flash
  logic hasSaved; // set by first finished save
  logic [1:0] writeWait; // slow write answer

  initial begin
    savedWord = 32'h0000_005a; // junk in a never-written store, only valid may be trusted
    hasSaved = 1'b0;
  end
  // released data flips so a stale read shows up
  assign nvReadData = nvReadAck ? savedWord : ~savedWord;
  assign nvReadValid = hasSaved;

  // store handshakes, one-cycle acks
  always @(posedge ref_clk) begin
    nvReadAck <= !rst && nvReadReq && !nvReadAck;
    if (rst) begin
      nvWriteAck <= 1'b0;
      writeWait <= 2'h0;
    end else if (nvWriteReq && !nvWriteAck) begin
      writeWait <= writeWait + 2'h1;
      if (writeWait == 2'h2) begin
        nvWriteAck <= 1'b1;
        savedWord <= nvWriteData;
        hasSaved <= 1'b1;
        writeWait <= 2'h0;
      end
    end else begin
      nvWriteAck <= 1'b0;
    end
  end

  // one unit a cycle, positive wins, halts on stop
  always @(posedge ref_clk) begin
    if (rst) begin
      motorPos <= 32'h0000_0100;
    end else if (stopRequest) begin
      motorPos <= motorPos;
    end else if (continuousMovePositive) begin
      motorPos <= motorPos + 32'h1;
    end else if (continuousMoveNegative) begin
      motorPos <= motorPos - 32'h1;
    end
  end
endmodule : osd_far_model

//--- verif/tb.sv
// Purpose: self-checking bench of the offset stop block
// Assumes: apb slave answers in the first access cycle
// Notes: store and motion come from osd_far_model
`timescale 1ns/10ps
module tb;
  import osd_pkg::*;
  // clock, reset, bus
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  // sequence, motion, trigger
  logic seqDistWr, seqSave, continuousMovePositive, continuousMoveNegative, triggerPin;
  logic [31:0] seqDistData, brakeDistance, motorPos, offsetVelocity, stopTarget;
  logic offsetVelSelect, decelRequest, stopRequest, offsetActive;
  // store
  logic nvReadReq, nvReadAck, nvReadValid, nvWriteReq, nvWriteAck;
  logic [31:0] nvReadData, nvWriteData;
  // bench state
  int errors = 0;
  int samples_checked = 0;
  logic [31:0] rd, cap;
  logic err;

  osd_offset_stop DUT (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .seqDistWr, .seqDistData, .seqSave, .motorPos, .continuousMovePositive,
    .continuousMoveNegative, .brakeDistance, .offsetVelSelect, .offsetVelocity, .decelRequest,
    .stopRequest, .stopTarget, .offsetActive, .triggerPin, .nvReadReq, .nvReadAck, .nvReadValid,
    .nvReadData, .nvWriteReq, .nvWriteData, .nvWriteAck);
  osd_far_model far (.ref_clk, .rst, .continuousMovePositive, .continuousMoveNegative,
    .stopRequest, .motorPos, .nvReadReq, .nvReadAck, .nvReadValid, .nvReadData, .nvWriteReq,
    .nvWriteData, .nvWriteAck);

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task complete_run;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      errors++;
    end
  endtask : chk

  // one apb transfer, result left in rd and err
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // an answer on the last allowed edge is still an answer
    if (pready !== 1'b1) begin
      errors++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("pslverr", {31'h0, e}, {31'h0, err});
  endtask : wr

  task rdc(input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk("prdata", ex, rd);
  endtask : rdc

  // bounded wait on one design output
  task wait_on(input int k);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 200) begin
      @(posedge ref_clk);
      n++;
      case (k)
        0: hit = nvWriteReq === 1'b1;
        1: hit = nvWriteReq === 1'b0;
        2: hit = nvReadReq === 1'b0;
        3: hit = offsetVelSelect === 1'b1;
        4: hit = decelRequest === 1'b1;
        default: hit = stopRequest === 1'b1;
      endcase
    end
    if (!hit) begin
      errors++;
      complete_run();
    end
  endtask : wait_on

  // reset, then let the power-up load land
  task do_reset;
    rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    wait_on(2);
    repeat (2) @(posedge ref_clk);
  endtask : do_reset

  // continuous move, trigger, and the offset stop if allowed
  task run_stop(input logic [31:0] ctl, input logic neg, input logic go);
    wr(OSD_ADDR_CTRL, ctl, 1'b0);
    continuousMovePositive <= !neg;
    continuousMoveNegative <= neg;
    repeat (2) @(posedge ref_clk);
    triggerPin <= 1'b1;
    if (go) begin
      wait_on(3);
      chk("decel early", 32'h0, {31'h0, decelRequest});
      chk("offset vel", 32'h5, offsetVelocity);
      apb(1'b0, OSD_ADDR_CAPPOS, 32'h0);
      cap = rd;
      chk("target", neg ? cap - 32'h18 : cap + 32'h18, stopTarget);
      wait_on(4);
      wait_on(5);
    end else begin
      repeat (12) @(posedge ref_clk);
      chk("active", 32'h0, {31'h0, offsetActive});
    end
    continuousMovePositive <= 1'b0;
    continuousMoveNegative <= 1'b0;
    triggerPin <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("idle", 32'h0, {31'h0, offsetActive});
  endtask : run_stop

  // hang guard
  initial begin
    repeat (50000) @(posedge ref_clk);
    errors++;
    complete_run();
  end

  // main sequence
  initial begin
    {rst, psel, penable, pwrite, seqDistWr, seqSave, triggerPin} = 7'b1000000;
    {continuousMovePositive, continuousMoveNegative} = 2'b00;
    paddr = 12'h0;
    pwdata = 32'h0;
    seqDistData = 32'h0;
    brakeDistance = 32'h4;
    do_reset();
    rdc(OSD_ADDR_DIST, OSD_DIST_INIT);
    rdc(OSD_ADDR_VEL, OSD_VEL_INIT);
    rdc(OSD_ADDR_MAX_POSITION_LIMIT, OSD_MAX_POSITION_LIMIT_INIT);
    rdc(OSD_ADDR_STAT, 32'h10);
    wr(12'h01c, 32'h7, 1'b1);
    rdc(12'h01c, 32'h0);
    wr(OSD_ADDR_DIST, 32'hffff, 1'b0);
    wr(OSD_ADDR_DIST, 32'h10000, 1'b1);
    rdc(OSD_ADDR_DIST, 32'hffff);
    rdc(OSD_ADDR_STAT, 32'h11);
    wr(OSD_ADDR_STAT, 32'h1, 1'b0);
    rdc(OSD_ADDR_STAT, 32'h10);
    chk("store write", 32'h0, {31'h0, nvWriteReq});
    wr(OSD_ADDR_CTRL, 32'h1, 1'b0);
    wr(OSD_ADDR_DIST, 32'h30, 1'b1);
    @(posedge ref_clk);
    seqDistWr <= 1'b1;
    seqDistData <= 32'h20;
    @(posedge ref_clk);
    seqDistWr <= 1'b0;
    rdc(OSD_ADDR_DIST, 32'h20);
    wr(OSD_ADDR_CTRL, 32'h0, 1'b0);
    wr(OSD_ADDR_CMD, 32'h1, 1'b0);
    rdc(OSD_ADDR_CMD, 32'h0);
    wait_on(0);
    chk("store data", 32'h20, nvWriteData);
    wait_on(1);
    wr(OSD_ADDR_DIST, 32'h40, 1'b0);
    rdc(OSD_ADDR_DIST, 32'h40);
    chk("store write", 32'h0, {31'h0, nvWriteReq});
    do_reset();
    rdc(OSD_ADDR_DIST, 32'h20);
    wr(OSD_ADDR_VEL, 32'h5, 1'b0);
    wr(OSD_ADDR_DIST, 32'h18, 1'b0);
    run_stop(32'h120, 1'b0, 1'b1);
    run_stop(32'h120, 1'b1, 1'b1);
    run_stop(32'h110, 1'b0, 1'b0);
    run_stop(32'h020, 1'b0, 1'b0);
    // save from a stored sequence, then a reset must bring it back
    seqSave <= 1'b1;
    @(posedge ref_clk);
    seqSave <= 1'b0;
    wait_on(0);
    chk("seq store data", 32'h18, nvWriteData);
    wait_on(1);
    do_reset();
    rdc(OSD_ADDR_DIST, 32'h18);
    complete_run();
  end
endmodule : tb
